// file: design/rfs_slave.v
// Serial front-end slave: identity, address-programming and revision registers.
`timescale 1ns/1ps
`default_nettype none
`include "rfs_map.vh"

module rfs_slave #(
    parameter [1:0] MAKER_CODE_HIGH = 2'h2,  // Arbitrary value.
    parameter [7:0] PRODUCT_CODE    = 8'h5A, // Arbitrary value.
    parameter [1:0] REV_MAJOR       = 2'h0,  // Arbitrary value.
    parameter [1:0] REV_MINOR       = 2'h0,  // Arbitrary value.
    parameter [3:0] REV_VARIANT     = 4'h3   // Arbitrary value.
) (
    input  wire       i_mclk,
    input  wire       i_resetn,
    input  wire       i_sclk,
    input  wire       i_sdata,
    output wire       o_sdata,
    output wire       o_sdata_oe,
    output wire [1:0] o_power_state_select,
    output wire       o_low_power,
    output wire [3:0] o_unique_slave_address
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_HDR  = 3'h1;
    localparam [2:0] ST_EADR = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_PARK = 3'h4;
    localparam [2:0] ST_RD   = 3'h5;
    localparam [2:0] ST_END  = 3'h6;

    wire sclk_fall;
    wire sclk_rise;
    wire ssc;
    wire sda;

    reg  [2:0]  state_reg;
    reg  [3:0]  cnt_reg;
    reg  [11:0] rx_reg;
    reg  [7:0]  addr_reg;
    reg         is_wr_reg;
    reg  [8:0]  tx_reg;
    reg         oe_reg;
    reg  [1:0]  psel_reg;
    reg  [3:0]  unique_slave_address_reg;
    reg         arm_reg;

    wire [12:0] hdr_full   = {rx_reg, sda};
    wire [8:0]  frame_full = {rx_reg[7:0], sda};
    wire [3:0]  hdr_sa     = hdr_full[12:9];
    wire [7:0]  hdr_cmd    = hdr_full[8:1];
    wire        sa_match   = (hdr_sa == unique_slave_address_reg);
    wire        sa_bcast   = (hdr_sa == 4'h0);

    rfs_pin_sampler u_sampler (
        .i_mclk      (i_mclk),
        .i_resetn    (i_resetn),
        .i_sclk      (i_sclk),
        .i_sdata     (i_sdata),
        .o_sclk_fall (sclk_fall),
        .o_sclk_rise (sclk_rise),
        .o_ssc       (ssc),
        .o_sdata     (sda)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Odd parity over data and its parity bit.
    function parity_ok9;
        input [8:0] f;
        begin
            parity_ok9 = ^f;
        end
    endfunction

    function [7:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `RFS_OFS_POWER_CTRL: read_mux = {psel_reg, 6'h00};
                `RFS_OFS_MAKER_ADDR:
                    read_mux = {2'h0, MAKER_CODE_HIGH, unique_slave_address_reg};
                `RFS_OFS_REVISION:
                    read_mux = {REV_MAJOR, REV_MINOR, REV_VARIANT};
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------------
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            rx_reg    <= 12'h000;
            addr_reg  <= 8'h00;
            is_wr_reg <= 1'b0;
            tx_reg    <= 9'h000;
            oe_reg    <= 1'b0;
            psel_reg  <= `RFS_RST_PSEL;
            unique_slave_address_reg  <= `RFS_RST_ADDR;
            arm_reg   <= 1'b0;
        end else if (ssc) begin
            state_reg <= ST_HDR;
            cnt_reg   <= 4'h0;
            rx_reg    <= 12'h000;
            oe_reg    <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    oe_reg <= 1'b0;
                end
                ST_HDR: begin
                    if (sclk_fall) begin
                        rx_reg  <= hdr_full[11:0];
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `RFS_HDR_LAST) begin
                            cnt_reg   <= 4'h0;
                            rx_reg    <= 12'h000;
                            state_reg <= ST_IDLE;
                            if (^hdr_full[8:0]) begin
                                if (hdr_cmd[7:5] == `RFS_CMD_WR &&
                                    (sa_match || sa_bcast)) begin
                                    addr_reg  <= {3'h0, hdr_cmd[4:0]};
                                    is_wr_reg <= 1'b1;
                                    state_reg <= ST_DATA;
                                end else if (hdr_cmd[7:5] == `RFS_CMD_RD &&
                                             sa_match) begin
                                    addr_reg  <= {3'h0, hdr_cmd[4:0]};
                                    is_wr_reg <= 1'b0;
                                    state_reg <= ST_PARK;
                                end else if (hdr_cmd[3:0] == 4'h0 &&
                                             hdr_cmd[7:4] == `RFS_CMD_EXT_WR &&
                                             (sa_match || sa_bcast)) begin
                                    is_wr_reg <= 1'b1;
                                    state_reg <= ST_EADR;
                                end else if (hdr_cmd[3:0] == 4'h0 &&
                                             hdr_cmd[7:4] == `RFS_CMD_EXT_RD &&
                                             sa_match) begin
                                    is_wr_reg <= 1'b0;
                                    state_reg <= ST_EADR;
                                end
                            end
                        end
                    end
                end
                ST_EADR: begin
                    if (sclk_fall) begin
                        rx_reg  <= {3'h0, frame_full};
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `RFS_FRAME_LAST) begin
                            cnt_reg  <= 4'h0;
                            rx_reg   <= 12'h000;
                            addr_reg <= frame_full[8:1];
                            if (!parity_ok9(frame_full))
                                state_reg <= ST_IDLE;
                            else if (is_wr_reg)
                                state_reg <= ST_DATA;
                            else
                                state_reg <= ST_PARK;
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_fall) begin
                        rx_reg  <= {3'h0, frame_full};
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `RFS_FRAME_LAST) begin
                            cnt_reg   <= 4'h0;
                            state_reg <= ST_IDLE;
                            if (parity_ok9(frame_full)) begin
                                arm_reg <= 1'b0;
                                case (addr_reg)
                                    `RFS_OFS_POWER_CTRL: begin
                                        // Startup codes restore defaults.
                                        if (frame_full[7]) begin
                                            psel_reg <= `RFS_RST_PSEL;
                                            unique_slave_address_reg <= `RFS_RST_ADDR;
                                        end else begin
                                            psel_reg <= frame_full[8:7];
                                        end
                                    end
                                    `RFS_OFS_PRODUCT: begin
                                        // First step of address programming.
                                        arm_reg <= (frame_full[8:1] ==
                                                    PRODUCT_CODE);
                                    end
                                    `RFS_OFS_MAKER_ADDR: begin
                                        // Maker bits are never stored.
                                        if (arm_reg && frame_full[6:5] ==
                                            MAKER_CODE_HIGH)
                                            unique_slave_address_reg <= frame_full[4:1];
                                    end
                                    default: begin
                                        arm_reg <= 1'b0;
                                    end
                                endcase
                            end
                        end
                    end
                end
                ST_PARK: begin
                    if (sclk_rise) begin
                        tx_reg    <= {read_mux(addr_reg),
                                      ~^read_mux(addr_reg)};
                        oe_reg    <= 1'b1;
                        cnt_reg   <= 4'h0;
                        state_reg <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (sclk_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        tx_reg  <= {tx_reg[7:0], 1'b0};
                        if (cnt_reg == `RFS_FRAME_LAST) begin
                            cnt_reg   <= 4'h0;
                            state_reg <= ST_END;
                        end
                    end
                end
                ST_END: begin
                    // Bus park: drive low for half a cycle, then release.
                    if (sclk_fall) begin
                        oe_reg    <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    oe_reg    <= 1'b0;
                end
            endcase
        end
    end

    assign o_sdata                = tx_reg[8];
    assign o_sdata_oe             = oe_reg;
    assign o_power_state_select   = psel_reg;
    assign o_low_power            = (psel_reg == `RFS_PSEL_LOW_POWER);
    assign o_unique_slave_address = unique_slave_address_reg;

endmodule // rfs_slave

`default_nettype wire

// file: design/rfs_map.vh
// Register offsets, field layouts, reset values and frame figures of the slave.
//
// Contract
// - Identity register bits 7:6 are reserved, read-only, always read zero.
// - Identity register bits 5:4 show the fixed upper maker code bits.
// - Address-programming write to identity register is accepted; maker bits stay.
// - Slave address bits 3:0 reset to 0x8; change only by programming sequence; a startup code to the power register also restores 0x8.
// - Revision register read-only: major 7:6, minor 5:4, mask variant 3:0.
// - Power state 10 is low power, antenna isolated; 00 is normal active.
`ifndef RFS_MAP_VH
`define RFS_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RFS_OFS_POWER_CTRL    8'h1C
`define RFS_OFS_PRODUCT       8'h1D
`define RFS_OFS_MAKER_ADDR    8'h1F
`define RFS_OFS_REVISION      8'h21

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RFS_PSEL_HI           7
`define RFS_PSEL_LO           6
`define RFS_MAKER_HI          5
`define RFS_MAKER_LO          4
`define RFS_ADDR_HI           3
`define RFS_ADDR_LO           0
`define RFS_RST_PSEL          2'h2
`define RFS_RST_ADDR          4'h8
`define RFS_PSEL_ACTIVE       2'h0
`define RFS_PSEL_LOW_POWER    2'h2

// ----------------------------------------------------------------------------
// Frame figures
// ----------------------------------------------------------------------------
`define RFS_HDR_LAST          4'hC
`define RFS_FRAME_LAST        4'h8
`define RFS_CMD_WR            3'h2
`define RFS_CMD_RD            3'h3
`define RFS_CMD_EXT_WR        4'h0
`define RFS_CMD_EXT_RD        4'h2

`endif

// file: design/rfs_pin_sampler.v
// Synchronises the serial clock and data pins and finds edges and start marks.
`timescale 1ns/1ps
`default_nettype none

module rfs_pin_sampler (
    input  wire i_mclk,
    input  wire i_resetn,
    input  wire i_sclk,
    input  wire i_sdata,
    output wire o_sclk_fall,
    output wire o_sclk_rise,
    output wire o_ssc,
    output wire o_sdata
);

    reg sclk_meta_reg;
    reg sclk_sync_reg;
    reg sclk_last_reg;
    reg sda_meta_reg;
    reg sda_sync_reg;
    reg sda_last_reg;

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_last_reg <= 1'b0;
            sda_meta_reg  <= 1'b0;
            sda_sync_reg  <= 1'b0;
            sda_last_reg  <= 1'b0;
        end else begin
            sclk_meta_reg <= i_sclk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_last_reg <= sclk_sync_reg;
            sda_meta_reg  <= i_sdata;
            sda_sync_reg  <= sda_meta_reg;
            sda_last_reg  <= sda_sync_reg;
        end
    end

    assign o_sclk_fall = sclk_last_reg & ~sclk_sync_reg;
    assign o_sclk_rise = ~sclk_last_reg & sclk_sync_reg;
    // A data fall while the clock rests low marks the start of a sequence.
    assign o_ssc       = sda_last_reg & ~sda_sync_reg & ~sclk_sync_reg;
    assign o_sdata     = sda_sync_reg;

endmodule // rfs_pin_sampler

`default_nettype wire

// file: verif/rfs_slave_assertions.sv
// Port-level checks of the serial front-end slave.
`timescale 1ns/1ps
`default_nettype none

module rfs_slave_assertions (
    input wire logic       i_mclk,
    input wire logic       i_resetn,
    input wire logic       o_sdata,
    input wire logic       o_sdata_oe,
    input wire logic [1:0] o_power_state_select,
    input wire logic       o_low_power,
    input wire logic [3:0] o_unique_slave_address
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    sequence s_rd_start; $rose(o_sdata_oe); endsequence
    sequence s_rd_hold; o_sdata_oe [*8]; endsequence
    sequence s_rd_end; ##[60:100] $fell(o_sdata_oe); endsequence
    property p_lp_decode;
        o_low_power == (o_power_state_select == 2'h2);
    endproperty
    property p_rst_state;
        $rose(i_resetn) |-> o_power_state_select == 2'h2
            && o_unique_slave_address == 4'h8 && !o_sdata_oe;
    endproperty
    property p_psel_legal;
        o_power_state_select == 2'h0 || o_power_state_select == 2'h2;
    endproperty
    property p_rd_hold; s_rd_start |-> s_rd_hold; endproperty
    property p_rd_end; s_rd_start |-> s_rd_end; endproperty
    property p_rd_no_write;
        o_sdata_oe |-> $stable(o_unique_slave_address)
            && $stable(o_power_state_select);
    endproperty
    property p_restore;
        $changed(o_unique_slave_address) && $changed(o_power_state_select)
            |-> o_unique_slave_address == 4'h8
            && o_power_state_select == 2'h2;
    endproperty
    property p_park; $fell(o_sdata_oe) |-> !$past(o_sdata); endproperty
    a_lp_decode: assert property (p_lp_decode)
        else $error("low power flag disagrees with power state");
    a_rst_state: assert property (p_rst_state)
        else $error("wrong state after reset");
    a_psel_legal: assert property (p_psel_legal)
        else $error("startup power state was stored");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read frame dropped early");
    a_rd_end: assert property (p_rd_end)
        else $error("read frame length wrong");
    a_rd_no_write: assert property (p_rd_no_write)
        else $error("register changed during read");
    a_restore: assert property (p_restore)
        else $error("restore gave wrong defaults");
    a_park: assert property (p_park)
        else $error("data not parked low before release");
endmodule // rfs_slave_assertions

bind rfs_slave rfs_slave_assertions u_chk (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .o_sdata(o_sdata),
    .o_sdata_oe(o_sdata_oe), .o_power_state_select(o_power_state_select),
    .o_low_power(o_low_power),
    .o_unique_slave_address(o_unique_slave_address));
`default_nettype wire

// file: verif/rfs_bus_master.sv
// Behavioural bus master driving the slave's clock and data pins.
`timescale 1ns/1ps
`default_nettype none

module rfs_bus_master (
    input  wire logic i_resetn,
    input  wire logic i_slave_sdata,
    input  wire logic i_slave_oe,
    output logic      o_sclk,
    output logic      o_sdata,
    output logic      o_radio_on
);
    logic    drv = 1'b0;
    logic    bit_q = 1'b1;
    logic    busy = 1'b0;
    realtime t_rst = 0.0, t_idle = 0.0, t_lp = 0.0;
    // A released line shows the inverse of the last bit, not a kept value.
    assign o_sdata = i_slave_oe ? i_slave_sdata : (drv ? bit_q : ~bit_q);
    initial o_sclk = 1'b0;
    initial o_radio_on = 1'b0;
    always @(posedge i_resetn) begin
        t_rst = $realtime;
        t_lp = $realtime;
    end
    always #100 if (!busy && $realtime - t_idle >= 2700.0) o_radio_on = 1'b1;
    task automatic clk_bit(input logic b);
        o_sclk = 1'b1;
        bit_q = b;
        #160 o_sclk = 1'b0;
        #160;
    endtask
    task automatic send(input logic [3:0] sa, input logic [7:0] cmd);
        while ($realtime - t_rst < 120.0) #10;
        busy = 1'b1;
        o_radio_on = 1'b0;
        drv = 1'b1;
        bit_q = 1'b1;
        #160 bit_q = 1'b0;
        #160;
        for (int i = 3; i >= 0; i--) clk_bit(sa[i]);
        for (int i = 7; i >= 0; i--) clk_bit(cmd[i]);
        clk_bit(~^cmd);
    endtask
    // Offsets beyond the short range go out as an extended sequence with a
    // byte count of zero, followed by the address frame.
    task automatic hdr(input logic [3:0] sa, input logic [7:0] ad,
                       input logic is_rd);
        if (ad[7:5] != 3'h0) begin
            send(sa, {2'b00, is_rd, 5'h00});
            for (int i = 7; i >= 0; i--) clk_bit(ad[i]);
            clk_bit(~^ad);
        end else begin
            send(sa, {2'b01, is_rd, ad[4:0]});
        end
    endtask
    task automatic done();
        drv = 1'b0;
        #320 busy = 1'b0;
        t_idle = $realtime;
    endtask
    task automatic do_write(input logic [3:0] sa, input logic [7:0] ad,
                            input logic [7:0] d, input logic bad);
        if (ad == 8'h1C && d[7:6] == 2'b00)
            while ($realtime - t_lp < 10000.0) #10;
        hdr(sa, ad, 1'b0);
        for (int i = 7; i >= 0; i--) clk_bit(d[i]);
        clk_bit(~^d ^ bad);
        clk_bit(1'b0);
        if (ad == 8'h1C && d[7:6] != 2'b00 && !bad) t_lp = $realtime;
        done();
    endtask
    task automatic do_read(input logic [3:0] sa, input logic [7:0] ad,
                           output logic [8:0] q);
        hdr(sa, ad, 1'b1);
        for (int i = 8; i >= 0; i--) begin
            o_sclk = 1'b1;
            drv = 1'b0;
            #150 q[i] = o_sdata;
            #10 o_sclk = 1'b0;
            #160;
        end
        clk_bit(1'b0);
        done();
    endtask
endmodule // rfs_bus_master
`default_nettype wire

// file: verif/rfs_slave_tb_top.sv
// Self-checking bench of the serial front-end slave.
`timescale 1ns/1ps
`default_nettype none

module rfs_slave_tb_top;
    localparam logic [1:0] MK = 2'h2; // Arbitrary value.
    localparam logic [7:0] PC = 8'h5A; // Arbitrary value.
    localparam logic [7:0] RV = 8'hB6; // Arbitrary value.
    logic       i_mclk, i_resetn, sclk, line, radio, sd, oe, lp;
    logic [1:0] psel;
    logic [3:0] addr;
    logic [8:0] q;
    int         n_fail = 0, checks_done = 0;
    rfs_slave #(.MAKER_CODE_HIGH(MK), .PRODUCT_CODE(PC), .REV_MAJOR(RV[7:6]),
        .REV_MINOR(RV[5:4]), .REV_VARIANT(RV[3:0])) u_dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk),
        .i_sdata(line), .o_sdata(sd), .o_sdata_oe(oe),
        .o_power_state_select(psel), .o_low_power(lp),
        .o_unique_slave_address(addr));
    rfs_bus_master u_master (.i_resetn(i_resetn), .i_slave_sdata(sd),
        .i_slave_oe(oe), .o_sclk(sclk), .o_sdata(line), .o_radio_on(radio));
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [8:0] s, e);
        checks_done++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    function automatic logic [8:0] px(input logic [7:0] d);
        return {d, ~^d};
    endfunction
    task automatic wr(input logic [3:0] sa, input logic [7:0] ad,
                      input logic [7:0] d, input logic bad = 1'b0);
        @(posedge i_mclk) #1 u_master.do_write(sa, ad, d, bad);
    endtask
    task automatic rd(input logic [3:0] sa, input logic [7:0] ad);
        @(posedge i_mclk) #1 u_master.do_read(sa, ad, q);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_reset();
        chk("psel", psel, 2'h2);
        chk("lp", lp, 1'b1);
        chk("addr", addr, 4'h8);
        rd(4'h8, 8'h1F);
        chk("id", q, px({2'b00, MK, 4'h8}));
        rd(4'h8, 8'h21);
        chk("rev", q, px(RV));
    endtask
    task automatic t_plain();
        wr(4'h8, 8'h1F, 8'hF3);
        rd(4'h8, 8'h1F);
        chk("id plain", q, px({2'b00, MK, 4'h8}));
        wr(4'h8, 8'h21, 8'h00);
        rd(4'h8, 8'h21);
        chk("rev ro", q, px(RV));
        wr(4'h8, 8'h1D, PC);
        wr(4'h8, 8'h1F, {2'b00, ~MK, 4'h3});
        chk("bad maker", addr, 4'h8);
    endtask
    task automatic t_program();
        wr(4'h8, 8'h1D, PC);
        wr(4'h0, 8'h1F, {2'b11, MK, 4'h5});
        chk("prog", addr, 4'h5);
        rd(4'h5, 8'h1F);
        chk("id prog", q, px({2'b00, MK, 4'h5}));
        wr(4'h5, 8'h1F, {2'b00, MK, 4'h7});
        chk("no arm", addr, 4'h5);
    endtask
    task automatic t_power();
        wr(4'h5, 8'h1C, 8'h00, 1'b1);
        wr(4'h3, 8'h1C, 8'h00);
        chk("refused", psel, 2'h2);
        wr(4'h5, 8'h1C, 8'h00);
        chk("active", {lp, psel}, 3'h0);
        rd(4'h5, 8'h1C);
        chk("pm rd", q, px(8'h00));
        wr(4'h5, 8'h1C, 8'h80);
        chk("low", {lp, psel}, 3'h6);
        chk("radio", radio, 1'b0);
        wr(4'h5, 8'h1C, 8'h00);
        wr(4'h5, 8'h1C, 8'h40);
        chk("restore", {lp, psel, addr}, 7'h68);
    endtask
    initial begin
        i_resetn = 1'b0;
        repeat (12) @(posedge i_mclk);
        #1 i_resetn = 1'b1;
        t_reset();
        t_plain();
        t_program();
        t_power();
        wrap_up();
    end
    initial begin
        #1_000_000 n_fail++;
        wrap_up();
    end
endmodule // rfs_slave_tb_top
`default_nettype wire
